// file: shared/sbes_pkg.sv
package sbes_pkg;

  localparam int unsigned SBES_BYTE_W    = 8;
  localparam int unsigned SBES_EXT_W     = 16;

  // Summary byte bit positions
  localparam int unsigned SB_ERR_Q_BIT   = 2;
  localparam int unsigned SB_EXT_SUM_BIT = 3;
  localparam int unsigned SB_OUT_Q_BIT   = 4;
  localparam int unsigned SB_STD_SUM_BIT = 5;
  localparam int unsigned SB_MASTER_BIT  = 6;

  // Bits that never read as one in the summary byte
  localparam logic [7:0] SB_UNUSED_MASK  = 8'h83;
  // Service enable bit that ignores writes and reads as zero
  localparam logic [7:0] SRE_WR_MASK     = 8'hBF;

  // Standard event latch bit positions
  localparam int unsigned EV_OP_DONE_BIT = 0;
  localparam int unsigned EV_REQ_CTL_BIT = 1;
  localparam int unsigned EV_QUERY_BIT   = 2;
  localparam int unsigned EV_DEVICE_BIT  = 3;
  localparam int unsigned EV_EXEC_BIT    = 4;
  localparam int unsigned EV_CMD_BIT     = 5;
  localparam int unsigned EV_USER_BIT    = 6;
  localparam int unsigned EV_POWER_BIT   = 7;

  // Bits held at zero in the standard event latch
  localparam logic [7:0] EV_LIVE_MASK    = 8'hBD;

  // Reset values
  localparam logic [7:0] EV_RESET        = 8'h80;
  localparam logic [7:0] ESE_RESET       = 8'h00;
  localparam logic [7:0] SRE_RESET       = 8'h00;
  localparam logic [7:0] BYTE_ZERO       = 8'h00;

  // Which value a response carries
  typedef enum logic [2:0] {
    SBES_RSP_NONE = 3'b000,
    SBES_RSP_POLL = 3'b001,
    SBES_RSP_STB  = 3'b010,
    SBES_RSP_ESR  = 3'b011,
    SBES_RSP_SRE  = 3'b100,
    SBES_RSP_ESE  = 3'b101
  } sbes_rsp_e;

endpackage : sbes_pkg

// file: shared/sbes_if.sv
`timescale 1ns/1ps
interface sbes_if;
  import sbes_pkg::*;

  logic                   ce;
  logic [SBES_BYTE_W-1:0] ev_set;
  logic                   ev_clear;
  logic                   ese_wr;
  logic                   sre_wr;
  logic [SBES_BYTE_W-1:0] wdata;
  logic [SBES_BYTE_W-1:0] std_event;
  logic [SBES_BYTE_W-1:0] ese_mask;
  logic                   std_summary;
  logic                   err_q;
  logic                   out_q;
  logic                   ext_sum;
  logic                   poll_done;
  logic [SBES_BYTE_W-1:0] summary_byte;
  logic                   request_service_latch;
  logic [SBES_BYTE_W-1:0] sre_mask;

  modport ctl (
    output ce, ev_set, ev_clear, ese_wr, sre_wr, wdata,
    output err_q, out_q, ext_sum, poll_done,
    input  std_event, ese_mask, summary_byte, request_service_latch, sre_mask
  );
  modport evt (
    input  ce, ev_set, ev_clear, ese_wr, wdata,
    output std_event, ese_mask, std_summary
  );
  modport sum (
    input  ce, sre_wr, wdata, std_summary, err_q, out_q, ext_sum,
    input  poll_done,
    output summary_byte, request_service_latch, sre_mask
  );
endinterface : sbes_if

// file: hdl/sbes_event_latch.sv
`timescale 1ns/1ps
module sbes_event_latch
  import sbes_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  sbes_if.evt      bus
);
  import sbes_pkg::*;

  logic [SBES_BYTE_W-1:0] event_reg;
  logic [SBES_BYTE_W-1:0] event_next;
  logic [SBES_BYTE_W-1:0] ese_reg;
  logic [SBES_BYTE_W-1:0] ese_next;

  always_comb begin
    event_next = event_reg;
    ese_next   = ese_reg;
    if (bus.ce) begin
      // New events win over a clear in the same cycle
      if (bus.ev_clear) begin
        event_next = BYTE_ZERO;
      end
      event_next = (event_next | bus.ev_set) & EV_LIVE_MASK;
      if (bus.ese_wr) begin
        ese_next = bus.wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      event_reg <= EV_RESET;
      ese_reg   <= ESE_RESET;
    end else begin
      event_reg <= event_next;
      ese_reg   <= ese_next;
    end
  end

  assign bus.std_event   = event_reg;
  assign bus.ese_mask    = ese_reg;
  assign bus.std_summary = |(event_reg & ese_reg);

endmodule : sbes_event_latch

// file: hdl/sbes_summary.sv
`timescale 1ns/1ps
module sbes_summary
  import sbes_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  sbes_if.sum      bus
);
  import sbes_pkg::*;

  logic [SBES_BYTE_W-1:0] sre_reg;
  logic [SBES_BYTE_W-1:0] sre_next;
  logic                   rqs_reg;
  logic                   rqs_next;
  logic                   master_prev_reg;
  logic                   master_prev_next;
  logic [SBES_BYTE_W-1:0] raw_byte;
  logic                   master_summary;

  always_comb begin
    raw_byte                 = BYTE_ZERO;
    raw_byte[SB_ERR_Q_BIT]   = bus.err_q;
    raw_byte[SB_EXT_SUM_BIT] = bus.ext_sum;
    raw_byte[SB_OUT_Q_BIT]   = bus.out_q;
    raw_byte[SB_STD_SUM_BIT] = bus.std_summary;
  end

  // Bit 6 of the enable never stores, so it cannot feed itself
  assign master_summary = |(raw_byte & sre_reg);

  always_comb begin
    sre_next         = sre_reg;
    rqs_next         = rqs_reg;
    master_prev_next = master_prev_reg;
    if (bus.ce) begin
      if (bus.sre_wr) begin
        sre_next = bus.wdata & SRE_WR_MASK;
      end
      master_prev_next = master_summary;
      if (bus.poll_done || !master_summary) begin
        rqs_next = 1'b0;
      end
      // A rising summary beats a poll clear in the same cycle
      if (master_summary && !master_prev_reg) begin
        rqs_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sre_reg         <= SRE_RESET;
      rqs_reg         <= 1'b0;
      master_prev_reg <= 1'b0;
    end else begin
      sre_reg         <= sre_next;
      rqs_reg         <= rqs_next;
      master_prev_reg <= master_prev_next;
    end
  end

  always_comb begin
    bus.summary_byte                = raw_byte;
    bus.summary_byte[SB_MASTER_BIT] = master_summary;
  end
  assign bus.request_service_latch      = rqs_reg;
  assign bus.sre_mask = sre_reg;

endmodule : sbes_summary

// file: hdl/sbes_top.sv
// Notes on behaviour
// - Bit 2 shows error queue not empty
// - Bit 3 is masked extended event OR
// - Bit 4 shows output queue not empty
// - Bit 5 is masked standard event OR
// - Master summary ORs enabled bits except six
// - Service latch sets on rise, clears poll/fall
// - Service request raised when bit six rises
// - Zero enable bit blocks summary and request
// - Status query reports master summary, clears nothing
// - Serial poll reports latch, clears latch only
// - Clear command clears event latch, not byte
// - Clear keeps output queue unless after terminator
// - Power-on flag set at switch-on
// - User request and request control stay zero
// - Command syntax error sets bit 5
// - Execution error sets bit 4
// - Device error sets bit 3
// - Query error sets bit 2
// - Operation complete sets bit 0
// - Zero event enable blocks event summary
// - Event query clears whole event latch
// - Clear command clears event latch; restart loads power-on flag only
// - Enable bit six ignored, reads zero
// - Operation complete set at once on command
`timescale 1ns/1ps
module sbes_top
  import sbes_pkg::*;
#(
  parameter int unsigned EXT_W = SBES_EXT_W
) (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           ce,
  // Command strobes from the message parser
  input  wire logic                           cmd_clear_status,
  input  wire logic                           cmd_after_terminator,
  input  wire logic                           cmd_op_complete,
  input  wire logic                           cmd_event_query,
  input  wire logic                           cmd_status_query,
  input  wire logic                           cmd_serial_poll,
  input  wire logic                           cmd_sre_write,
  input  wire logic                           cmd_sre_query,
  input  wire logic                           cmd_ese_write,
  input  wire logic                           cmd_ese_query,
  input  wire logic [sbes_pkg::SBES_BYTE_W-1:0] cmd_wdata,
  // Event pulses
  input  wire logic                           command_error_flag,
  input  wire logic                           execution_error_flag,
  input  wire logic                           device_error_flag,
  input  wire logic                           query_error_flag,
  // Queue levels and extended event state
  input  wire logic                           error_queue_nonempty,
  input  wire logic                           output_queue_nonempty,
  input  wire logic [EXT_W-1:0]               ext_event,
  input  wire logic [EXT_W-1:0]               ext_enable,
  // Answers
  output logic                                rsp_valid,
  output logic [sbes_pkg::SBES_BYTE_W-1:0]    rsp_data,
  output logic                                service_request,
  output logic                                output_queue_clear,
  output logic [sbes_pkg::SBES_BYTE_W-1:0]    service_summary_byte,
  output logic [sbes_pkg::SBES_BYTE_W-1:0]    standard_event_latch
);
  import sbes_pkg::*;

  sbes_if bus ();

  logic [EXT_W-1:0]       ext_hit;
  logic [SBES_BYTE_W-1:0] ev_set;
  sbes_rsp_e              rsp_sel;

  logic                   rsp_valid_reg;
  logic                   rsp_valid_next;
  logic [SBES_BYTE_W-1:0] rsp_data_reg;
  logic [SBES_BYTE_W-1:0] rsp_data_next;
  logic                   srq_reg;
  logic                   srq_next;
  logic                   oq_clear_reg;
  logic                   oq_clear_next;
  logic [SBES_BYTE_W-1:0] sb_out_reg;
  logic [SBES_BYTE_W-1:0] sb_out_next;
  logic [SBES_BYTE_W-1:0] ev_out_reg;
  logic [SBES_BYTE_W-1:0] ev_out_next;
  logic                   poll_reg;
  logic                   poll_next;

  // Per-bit extended event masking
  genvar gi;
  generate
    for (gi = 0; gi < EXT_W; gi++) begin : g_ext
      assign ext_hit[gi] = ext_event[gi] & ext_enable[gi];
    end
  endgenerate

  // Event sources into the standard event latch
  always_comb begin
    ev_set                 = BYTE_ZERO;
    ev_set[EV_CMD_BIT]     = command_error_flag;
    ev_set[EV_EXEC_BIT]    = execution_error_flag;
    ev_set[EV_DEVICE_BIT]  = device_error_flag;
    ev_set[EV_QUERY_BIT]   = query_error_flag;
    ev_set[EV_OP_DONE_BIT] = cmd_op_complete;
  end

  assign bus.ce        = ce;
  assign bus.ev_set    = ev_set;
  assign bus.ev_clear  = cmd_clear_status | cmd_event_query;
  assign bus.ese_wr    = cmd_ese_write;
  assign bus.sre_wr    = cmd_sre_write;
  assign bus.wdata     = cmd_wdata;
  assign bus.err_q     = error_queue_nonempty;
  assign bus.out_q     = output_queue_nonempty;
  assign bus.ext_sum   = |ext_hit;
  assign bus.poll_done = poll_reg;

  sbes_event_latch u_event (
    .clk   (clk),
    .reset (reset),
    .bus   (bus.evt)
  );

  sbes_summary u_summary (
    .clk   (clk),
    .reset (reset),
    .bus   (bus.sum)
  );

  // One query answered per cycle; serial poll has priority
  always_comb begin
    if (cmd_serial_poll) begin
      rsp_sel = SBES_RSP_POLL;
    end else if (cmd_status_query) begin
      rsp_sel = SBES_RSP_STB;
    end else if (cmd_event_query) begin
      rsp_sel = SBES_RSP_ESR;
    end else if (cmd_sre_query) begin
      rsp_sel = SBES_RSP_SRE;
    end else if (cmd_ese_query) begin
      rsp_sel = SBES_RSP_ESE;
    end else begin
      rsp_sel = SBES_RSP_NONE;
    end
  end

  always_comb begin
    rsp_valid_next = rsp_valid_reg;
    rsp_data_next  = rsp_data_reg;
    srq_next       = srq_reg;
    oq_clear_next  = oq_clear_reg;
    sb_out_next    = sb_out_reg;
    ev_out_next    = ev_out_reg;
    poll_next      = poll_reg;
    if (ce) begin
      rsp_valid_next = (rsp_sel != SBES_RSP_NONE);
      case (rsp_sel)
        SBES_RSP_POLL: begin
          rsp_data_next = bus.summary_byte;
          rsp_data_next[SB_MASTER_BIT] = bus.request_service_latch;
        end
        SBES_RSP_STB: begin
          rsp_data_next = bus.summary_byte;
        end
        SBES_RSP_ESR: begin
          rsp_data_next = bus.std_event;
        end
        SBES_RSP_SRE: begin
          rsp_data_next = bus.sre_mask;
        end
        SBES_RSP_ESE: begin
          rsp_data_next = bus.ese_mask;
        end
        default: begin
          rsp_data_next = rsp_data_reg;
        end
      endcase
      // Latch is cleared the cycle after the polled byte is taken
      poll_next = (rsp_sel == SBES_RSP_POLL);
      srq_next  = bus.request_service_latch;
      oq_clear_next = cmd_clear_status & cmd_after_terminator;
      sb_out_next = bus.summary_byte & ~SB_UNUSED_MASK;
      ev_out_next = bus.std_event;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= BYTE_ZERO;
      srq_reg       <= 1'b0;
      oq_clear_reg  <= 1'b0;
      sb_out_reg    <= BYTE_ZERO;
      ev_out_reg    <= EV_RESET;
      poll_reg      <= 1'b0;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
      srq_reg       <= srq_next;
      oq_clear_reg  <= oq_clear_next;
      sb_out_reg    <= sb_out_next;
      ev_out_reg    <= ev_out_next;
      poll_reg      <= poll_next;
    end
  end

  assign rsp_valid            = rsp_valid_reg;
  assign rsp_data             = rsp_data_reg;
  assign service_request      = srq_reg;
  assign output_queue_clear   = oq_clear_reg;
  assign service_summary_byte = sb_out_reg;
  assign standard_event_latch = ev_out_reg;

endmodule : sbes_top

// file: tb/sbes_sva.sv
`timescale 1ns/1ps
module sbes_sva
  import sbes_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   ce,
  input wire logic                   cmd_clear_status,
  input wire logic                   cmd_after_terminator,
  input wire logic                   cmd_op_complete,
  input wire logic                   cmd_event_query,
  input wire logic                   cmd_status_query,
  input wire logic                   cmd_serial_poll,
  input wire logic                   command_error_flag,
  input wire logic                   execution_error_flag,
  input wire logic                   device_error_flag,
  input wire logic                   query_error_flag,
  input wire logic                   rsp_valid,
  input wire logic [SBES_BYTE_W-1:0] rsp_data,
  input wire logic                   service_request,
  input wire logic                   output_queue_clear,
  input wire logic [SBES_BYTE_W-1:0] service_summary_byte,
  input wire logic [SBES_BYTE_W-1:0] standard_event_latch
);
  wire logic [5:0] ev_in = {command_error_flag, execution_error_flag,
    device_error_flag, query_error_flag, 1'b0, cmd_op_complete};
  wire logic       quiet = ~|ev_in;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  unused_bits_a:
    assert property ((service_summary_byte & SB_UNUSED_MASK) == 8'h00)
    else $error("summary byte unused bit set");
  fixed_events_a:
    assert property ((standard_event_latch & ~EV_LIVE_MASK) == 8'h00)
    else $error("event latch fixed bit set");
  stb_answer_a:
    assert property (ce && cmd_status_query && !cmd_serial_poll |=>
      rsp_valid && rsp_data == service_summary_byte)
    else $error("status query answer wrong");
  poll_answer_a:
    assert property (ce && cmd_serial_poll |=> rsp_valid && rsp_data ==
      {service_summary_byte[7], service_request, service_summary_byte[5:0]})
    else $error("serial poll answer wrong");
  srq_rise_a:
    assert property ($rose(service_summary_byte[6]) |=> service_request)
    else $error("no service request after summary rise");
  poll_clear_a:
    assert property (ce && cmd_serial_poll ##2
      !$rose(service_summary_byte[6]) |=> !service_request)
    else $error("service request kept after poll");
  esr_read_a:
    assert property (ce && cmd_event_query && !cmd_serial_poll &&
      !cmd_status_query && quiet |=> rsp_valid &&
      rsp_data == standard_event_latch ##1 standard_event_latch == 8'h00)
    else $error("event query read or clear wrong");
  event_set_a:
    assert property (ce |=> ##1
      (standard_event_latch[5:0] & $past(ev_in, 2)) == $past(ev_in, 2))
    else $error("event not latched");
  clear_status_a:
    assert property (ce && cmd_clear_status && quiet |=> ##1
      standard_event_latch == 8'h00)
    else $error("clear left event latch set");
  queue_clear_a:
    assert property (ce |=> output_queue_clear ==
      $past(cmd_clear_status && cmd_after_terminator))
    else $error("output queue clear wrong");
endmodule : sbes_sva

// file: tb/sbes_ctl_model.sv
`timescale 1ns/1ps
module sbes_ctl_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       service_request,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  input  wire logic       auto_en,
  input  wire logic       poll_req,
  input  wire logic [3:0] wait_n,
  output logic            poll,
  output logic [7:0]      poll_byte,
  output logic            poll_seen
);
  logic [3:0] cnt;
  logic [2:0] st;
  // Idle, delay, poll, await answer, await request drop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= 3'd0;
      cnt <= 4'd0;
      poll <= 1'b0;
      poll_seen <= 1'b0;
      poll_byte <= 8'h00;
    end else begin
      poll_seen <= 1'b0;
      case (st)
        3'd0: if (poll_req || (auto_en && service_request)) begin
          cnt <= wait_n;
          st <= 3'd1;
        end
        3'd1: begin
          cnt <= cnt - 4'd1;
          poll <= cnt == 4'd0;
          if (cnt == 4'd0) st <= 3'd2;
        end
        3'd2: begin
          poll <= 1'b0;
          st <= 3'd3;
        end
        3'd3: if (rsp_valid) begin
          poll_byte <= rsp_data;
          poll_seen <= 1'b1;
          st <= 3'd4;
        end
        default: if (!service_request) st <= 3'd0;
      endcase
    end
  end
endmodule : sbes_ctl_model

// file: tb/tb_status_byte_event_summary.sv
`timescale 1ns/1ps
module tb_status_byte_event_summary;
  import sbes_pkg::*;
  typedef struct packed {
    logic [7:0] sre;
    logic [7:0] ese;
    logic [3:0] ev;
    logic [2:0] lv;
    logic [7:0] stb;
  } sbes_row_s;
  // Service enable, event enable, events, queue levels, status byte
  sbes_row_s rows [8] = '{
    '{8'hFF, 8'h20, 4'h8, 3'h0, 8'h60}, '{8'hDF, 8'h20, 4'h8, 3'h0, 8'h20},
    '{8'hFF, 8'h10, 4'h8, 3'h0, 8'h00}, '{8'h04, 8'h00, 4'h0, 3'h4, 8'h44},
    '{8'h08, 8'h00, 4'h0, 3'h1, 8'h48}, '{8'h10, 8'h00, 4'h0, 3'h2, 8'h50},
    '{8'hFF, 8'h3C, 4'hF, 3'h7, 8'h7C}, '{8'h40, 8'h00, 4'h0, 3'h7, 8'h1C}};
  logic       clk, reset, ce, term, auto_en, poll_req, poll, poll_seen;
  logic       rsp_valid, srq, oqc;
  logic [7:0] cmd_v, wdata, rsp_data, ssb, sel, poll_byte;
  logic [3:0] ev, wait_n;
  logic [2:0] lv;
  int         fails, check_count;

  sbes_top dut_u (
    .clk(clk), .reset(reset), .ce(ce),
    .cmd_clear_status(cmd_v[0]), .cmd_after_terminator(term),
    .cmd_op_complete(cmd_v[1]), .cmd_event_query(cmd_v[2]),
    .cmd_status_query(cmd_v[3]), .cmd_serial_poll(poll),
    .cmd_sre_write(cmd_v[4]), .cmd_sre_query(cmd_v[5]),
    .cmd_ese_write(cmd_v[6]), .cmd_ese_query(cmd_v[7]),
    .cmd_wdata(wdata), .command_error_flag(ev[3]),
    .execution_error_flag(ev[2]), .device_error_flag(ev[1]),
    .query_error_flag(ev[0]), .error_queue_nonempty(lv[2]),
    .output_queue_nonempty(lv[1]), .ext_event(16'h0100),
    .ext_enable(lv[0] ? 16'h0100 : 16'hFEFF), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .service_request(srq),
    .output_queue_clear(oqc), .service_summary_byte(ssb),
    .standard_event_latch(sel));
  sbes_ctl_model ctl_u (
    .clk(clk), .reset(reset), .service_request(srq),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .auto_en(auto_en),
    .poll_req(poll_req), .wait_n(wait_n), .poll(poll),
    .poll_byte(poll_byte), .poll_seen(poll_seen));

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic op(input int k, input logic [7:0] d);
    @(posedge clk);
    cmd_v <= 8'(1 << k);
    wdata <= d;
    @(posedge clk);
    cmd_v <= 8'h00;
    #1;
  endtask : op
  task automatic wait_poll();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (poll_seen) break;
    end
  endtask : wait_poll
  task automatic run_row(input sbes_row_s r);
    @(posedge clk) lv <= r.lv;
    op(4, r.sre);
    op(6, r.ese);
    op(2, 8'h00);
    @(posedge clk) ev <= r.ev;
    @(posedge clk) ev <= 4'h0;
    repeat (2) @(posedge clk);
    op(3, 8'h00);
    chk_bit(rsp_valid, 1'b1);
    chk_byte(rsp_data, r.stb);
    op(5, 8'h00);
    chk_byte(rsp_data, r.sre & SRE_WR_MASK);
    op(2, 8'h00);
    chk_byte(rsp_data, {2'b00, r.ev, 2'b00});
  endtask : run_row

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2_000_000;
    fails++;
    wrap_up();
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {cmd_v, term, wdata, ev, lv, auto_en, poll_req, wait_n} = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    // Last row masked every source, so the latch fell with the summary
    chk_bit(srq, 1'b0);
    // Slow controller answers the request raised by an enabled event
    @(posedge clk) lv <= 3'h0;
    op(4, 8'h20);
    op(6, 8'h01);
    @(posedge clk) begin
      auto_en <= 1'b1;
      wait_n <= 4'd5;
    end
    op(1, 8'h00);
    wait_poll();
    chk_bit(poll_seen, 1'b1);
    chk_byte(poll_byte, 8'h60);
    repeat (3) @(posedge clk);
    #1;
    chk_bit(srq, 1'b0);
    op(3, 8'h00);
    chk_byte(rsp_data, 8'h60);
    // Prompt poll with no new rise sees the latch already cleared
    @(posedge clk) begin
      auto_en <= 1'b0;
      poll_req <= 1'b1;
      wait_n <= 4'd0;
    end
    @(posedge clk) poll_req <= 1'b0;
    wait_poll();
    chk_byte(poll_byte, 8'h20);
    op(0, 8'h00);
    chk_bit(oqc, 1'b0);
    @(posedge clk) term <= 1'b1;
    op(0, 8'h00);
    chk_bit(oqc, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk_byte(sel, 8'h00);
    chk_byte(ssb, 8'h00);
    // Commands while the clock enable is low leave no trace
    @(posedge clk) ce <= 1'b0;
    op(1, 8'h00);
    op(3, 8'h00);
    chk_bit(rsp_valid, 1'b0);
    @(posedge clk) ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_byte(sel, 8'h00);
    @(posedge clk) begin
      reset <= 1'b1;
      term <= 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
    chk_byte(sel, EV_RESET);
    @(posedge clk) reset <= 1'b0;
    op(5, 8'h00);
    chk_byte(rsp_data, 8'h00);
    op(7, 8'h00);
    chk_byte(rsp_data, 8'h00);
    wrap_up();
  end
endmodule : tb_status_byte_event_summary

bind sbes_top sbes_sva chk_u (
  .clk(clk), .reset(reset), .ce(ce), .cmd_clear_status(cmd_clear_status),
  .cmd_after_terminator(cmd_after_terminator),
  .cmd_op_complete(cmd_op_complete), .cmd_event_query(cmd_event_query),
  .cmd_status_query(cmd_status_query), .cmd_serial_poll(cmd_serial_poll),
  .command_error_flag(command_error_flag),
  .execution_error_flag(execution_error_flag),
  .device_error_flag(device_error_flag),
  .query_error_flag(query_error_flag), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .service_request(service_request),
  .output_queue_clear(output_queue_clear),
  .service_summary_byte(service_summary_byte),
  .standard_event_latch(standard_event_latch));
